// file: adc_device.sv
// Converter device end: serial port and conversion sequencer.
// Assumes link_srst is synchronous to the conversion clock, and sample_code
// is the digitised level of the channel on chan_sel, in the same domain.
`timescale 1ns/1ns
`include "adc_seq_consts.svh"

// Behaviour
// - Each result is exactly 10 bits.
// - Conversion finishes within 44 conversion clocks.
// - Transfer lasts 10 to 16 serial clocks.
// - Acquisition window spans six serial clocks.
// - Host supplies conversion clock 500 kHz-2.1 MHz.
// - Output driven after two-clock select synchronisation.
// - Host waits setup before first serial edge.
// - Host leaves 44 clocks before next select.
// - Early select after tenth fall aborts conversion.
// - Long transfers need a rise within 38.
// - Select accepted right after done goes active.
// - Done goes low after the tenth edge.
// - MSB appears with done going active.
// - Host spaces sample cycles by the minimum.
// - Address captured MSB first on four rises.
// - Result shifts MSB first, then zeros.
// - Abort returns to shift, keeps older result.
// - Select fall realigns; high floats output.
module adc_device (
  input wire logic link_srst, // Reset, sync to conversion clock
  adc_link_if.device link, // Serial link pins
  input wire adc_seq_pkg::result_t sample_code, // Level of selected channel
  output adc_seq_pkg::addr_t chan_sel, // Channel under acquisition
  output adc_seq_pkg::result_t result_code // Last completed result
);
  import adc_seq_pkg::*;

  // Whole device state
  typedef struct packed {
    dev_state_t st; // Sequencer state
    logic cs_prev; // Synchronised select, one cycle late
    logic sclk_prev; // Synchronised serial clock, one cycle late
    logic [4:0] rises; // Rising edges in this transfer, counted up to four
    logic [4:0] falls; // Falling edges in this transfer
    addr_t addr; // Address shift register
    addr_t chan; // Channel being sampled
    result_t shreg; // Outgoing result bits
    result_t result; // Output data register
    result_t sample; // Held sample under conversion
    logic [5:0] cnt; // Conversion clock count
    logic dout; // Result line value
    logic done; // Conversion done level
  } dev_reg_t;

  dev_reg_t q; // Current state
  dev_reg_t d; // Next state
  logic [2:0] pins_s; // Synchronised select, serial clock, data
  logic cs_s; // Synchronised select
  logic sclk_s; // Synchronised serial clock
  logic din_s; // Synchronised data input
  logic cs_fall; // Recognised select fall
  logic sclk_rise; // Serial clock rise while selected
  logic sclk_fall; // Serial clock fall while selected

  // Link pins are foreign to this clock; two flops before any use
  adc_sync2 #(
    .W(3)
  ) u_pin_sync (
    .clk(link.conversion_clock),
    .d({link.cs_n, link.sclk, link.din}),
    .q(pins_s)
  );

  assign cs_s = pins_s[2];
  assign sclk_s = pins_s[1];
  assign din_s = pins_s[0];

  // A select level counts only after two conversion clocks
  assign cs_fall = q.cs_prev & ~cs_s;
  // Serial clock and data ignored while deselected. The select level of the
  // previous cycle gates the edges, because the host may raise the select on
  // the very edge of its last fall; both pins then cross in the same flop and
  // gating by the current level would lose the tenth fall.
  assign sclk_rise = ~q.cs_prev & sclk_s & ~q.sclk_prev;
  assign sclk_fall = ~q.cs_prev & ~sclk_s & q.sclk_prev;

  // Next-state logic for conversion and serial port
  always_comb
  begin
    d = q;
    d.cs_prev = cs_s;
    d.sclk_prev = sclk_s;

    // Conversion sequence; last step updates the output data register
    if (q.st == DEV_CONV)
    begin
      d.cnt = q.cnt + 6'h01;
      if (q.cnt == `CONV_CYCLES - 6'h01)
      begin
        d.result = q.sample;
        d.st = DEV_IDLE;
        d.done = 1'b1;
        // Select held low: end of conversion restarts the port
        if (!cs_s && (q.falls == `LAST_FALL || q.falls == `MAX_FALLS))
        begin
          d.rises = 5'h00;
          d.falls = 5'h00;
          d.shreg = q.sample;
          d.dout = q.sample[`RESULT_MSB];
          d.st = DEV_SHIFT;
        end
      end
    end

    if (cs_fall)
    begin
      // Select fall resets and realigns the port
      d.rises = 5'h00;
      d.falls = 5'h00;
      d.shreg = q.result;
      d.dout = q.result[`RESULT_MSB];
      if (q.st == DEV_CONV)
      begin
        // Early enough: abandon, keep the older result
        if (q.cnt < `ABORT_CYCLES)
        begin
          d.st = DEV_SHIFT;
          d.cnt = 6'h00;
          d.done = 1'b1;
        end
      end
      else
      begin
        d.st = DEV_SHIFT;
      end
    end
    else if (!q.cs_prev)
    begin
      // Address bits on the first four rises, MSB first
      if (sclk_rise && q.rises < `ADDR_RISES)
      begin
        d.addr = {q.addr[`ADDR_W-2:0], din_s};
        d.rises = q.rises + 5'h01;
        // Fourth bit makes the channel known: acquisition opens
        if (q.rises == `ACQ_START_RISE)
        begin
          d.chan = {q.addr[`ADDR_W-2:0], din_s};
        end
      end

      if (sclk_fall)
      begin
        if (q.falls < `MAX_FALLS)
        begin
          d.falls = q.falls + 5'h01;
        end
        if (q.falls < `LAST_FALL - 5'h01)
        begin
          // Next bit, MSB first
          d.shreg = {q.shreg[`RESULT_W-2:0], 1'b0};
          d.dout = q.shreg[`RESULT_MSB-1];
        end
        else
        begin
          // Tenth fall and later read zeros
          d.dout = 1'b0;
        end
        if (q.falls == `LAST_FALL - 5'h01 && q.st != DEV_CONV)
        begin
          // Acquisition closes six clocks after it opened; convert
          d.sample = sample_code;
          d.st = DEV_CONV;
          d.cnt = 6'h00;
          d.done = 1'b0;
        end
        // Sixteenth fall after a finished conversion restarts the port
        if (q.falls == `MAX_FALLS - 5'h01 && q.st != DEV_CONV)
        begin
          d.rises = 5'h00;
          d.falls = 5'h00;
          d.shreg = q.result;
          d.dout = q.result[`RESULT_MSB];
          d.st = DEV_SHIFT;
        end
      end
    end

    // Power-up: idle, waiting for a select
    if (link_srst)
    begin
      d.st = DEV_IDLE;
      d.cs_prev = 1'b1;
      d.sclk_prev = 1'b0;
      d.rises = 5'h00;
      d.falls = 5'h00;
      d.addr = '0;
      d.chan = '0;
      d.shreg = `RESULT_RESET;
      d.result = `RESULT_RESET;
      d.sample = `RESULT_RESET;
      d.cnt = 6'h00;
      d.dout = 1'b0;
      d.done = 1'b1;
    end
  end

  // State register on the conversion clock
  always_ff @(posedge link.conversion_clock)
  begin
    q <= d;
  end

  // Line is driven only while the select is recognised low
  assign link.dout_oe = ~cs_s & ~link_srst;
  assign link.dout = q.dout;
  assign link.conversion_done = q.done;
  assign chan_sel = q.chan;
  assign result_code = q.result;
endmodule // adc_device

// file: adc_host.sv
// Host end: makes the conversion clock and runs one serial transfer per start.
// Assumes a 100 MHz clk; the result line is asynchronous and synchronised here.
`timescale 1ns/1ns
`include "adc_seq_consts.svh"

module adc_host (
  input wire logic clk, // System clock
  input wire logic srst, // Synchronous reset, active high
  adc_link_if.host link, // Serial link pins
  input wire logic start, // Begin a transfer
  input wire adc_seq_pkg::addr_t chan, // Next channel to convert
  input wire logic [4:0] xfer_len, // Serial clocks per transfer
  output logic busy, // Transfer or gap in progress
  output adc_seq_pkg::result_t result, // Previous conversion result
  output logic result_valid // Result updated this cycle
);
  import adc_seq_pkg::*;

  // Whole host state
  typedef struct packed {
    host_state_t st; // Sequencer state
    logic [11:0] tmr; // Phase timer in clk cycles
    logic [4:0] nclk; // Serial clocks given
    logic [4:0] len; // Clamped transfer length
    addr_t addr; // Address bits still to send
    result_t rx; // Received result bits
    result_t result; // Last full result
    logic valid; // Result strobe
    logic cs_n; // Chip select pin
    logic sclk; // Serial clock pin
    logic din; // Data pin
    logic [5:0] div; // Clock divider count
    logic conv_clk; // Conversion clock pin
  } host_reg_t;

  host_reg_t q; // Current state
  host_reg_t d; // Next state
  logic dout_s; // Synchronised result line

  // Result line comes from the device's domain
  adc_sync2 #(
    .W(1)
  ) u_dout_sync (
    .clk(clk),
    .d(link.dout_line),
    .q(dout_s)
  );

  // Next-state logic
  always_comb
  begin
    d = q;
    d.valid = 1'b0;
    d.tmr = q.tmr + 12'h001;

    // Divide by 48: about 2.08 MHz, inside the allowed band
    d.div = q.div + 6'h01;
    if (q.div == `CONV_HALF_CYC - 6'h01)
    begin
      d.div = 6'h00;
      d.conv_clk = ~q.conv_clk;
    end

    case (q.st)
      H_IDLE:
      begin
        d.tmr = 12'h000;
        if (start)
        begin
          // Lengths outside ten to sixteen are clamped
          d.len = (xfer_len < `LAST_FALL) ? `LAST_FALL :
            (xfer_len > `MAX_FALLS) ? `MAX_FALLS : xfer_len;
          d.addr = {chan[`ADDR_W-2:0], 1'b0};
          d.din = chan[`ADDR_W-1];
          d.cs_n = 1'b0;
          d.nclk = 5'h00;
          d.st = H_SETUP;
        end
      end
      H_SETUP:
      begin
        // Hold off the first edge until the select is recognised
        if (q.tmr == `CS_SETUP_CYC - 12'h001)
        begin
          d.tmr = 12'h000;
          d.st = H_LOW;
        end
      end
      H_LOW:
      begin
        if (q.tmr == `SCLK_HALF_CYC - 12'h001)
        begin
          d.tmr = 12'h000;
          d.sclk = 1'b1;
          // First ten rises catch the result, MSB first
          if (q.nclk < `LAST_FALL)
          begin
            d.rx = {q.rx[`RESULT_W-2:0], dout_s};
          end
          d.st = H_HIGH;
        end
      end
      H_HIGH:
      begin
        // Half periods are short, so a rise follows the tenth fall in time
        if (q.tmr == `SCLK_HALF_CYC - 12'h001)
        begin
          d.tmr = 12'h000;
          d.sclk = 1'b0;
          d.nclk = q.nclk + 5'h01;
          d.din = q.addr[`ADDR_W-1];
          d.addr = {q.addr[`ADDR_W-2:0], 1'b0};
          d.st = H_LOW;
          if (q.nclk + 5'h01 == q.len)
          begin
            d.cs_n = 1'b1;
            d.din = 1'b0;
            d.result = q.rx;
            d.valid = 1'b1;
            d.st = H_GAP;
          end
        end
      end
      H_GAP:
      begin
        // Let the conversion finish before the next select
        if (q.tmr == `ALLOW_GAP_CYC - 12'h001)
        begin
          d.st = H_IDLE;
        end
      end
      default:
      begin
        d.st = H_IDLE;
      end
    endcase

    if (srst)
    begin
      d.st = H_IDLE;
      d.tmr = 12'h000;
      d.nclk = 5'h00;
      d.len = `LAST_FALL;
      d.addr = '0;
      d.rx = `RESULT_RESET;
      d.result = `RESULT_RESET;
      d.valid = 1'b0;
      d.cs_n = 1'b1;
      d.sclk = 1'b0;
      d.din = 1'b0;
      d.div = 6'h00;
      d.conv_clk = 1'b0;
    end
  end

  // State register
  always_ff @(posedge clk)
  begin
    q <= d;
  end

  // Gap keeps busy high, so starts are spaced by a full cycle
  assign busy = (q.st != H_IDLE);
  assign result = q.result;
  assign result_valid = q.valid;
  assign link.conversion_clock = q.conv_clk;
  assign link.cs_n = q.cs_n;
  assign link.sclk = q.sclk;
  assign link.din = q.din;
endmodule // adc_host

// file: adc_link_if.sv
// Serial link between the host and the converter device.
// Assumes the host drives the conversion clock; the result line is resolved here.
`timescale 1ns/1ns

interface adc_link_if;
  logic conversion_clock; // Conversion clock made by the host
  logic cs_n; // Chip select, active low
  logic sclk; // Serial clock
  logic din; // Address bits to the device
  logic dout; // Result bit from the device
  logic dout_oe; // Device drives the result line
  logic conversion_done; // High when no conversion is running
  logic dout_line; // Resolved result line

  // Undriven line reads high, as a pull-up would leave it
  assign dout_line = dout_oe ? dout : 1'b1;

  modport device (
    input conversion_clock,
    input cs_n,
    input sclk,
    input din,
    output dout,
    output dout_oe,
    output conversion_done
  );

  modport host (
    output conversion_clock,
    output cs_n,
    output sclk,
    output din,
    input dout_line,
    input conversion_done
  );
endinterface

// file: adc_seq_checker.sv
// Concurrent checks on the serial link between the host and the converter.
// Assumes it sits beside the link and sees the device reset and conversion clock.
`timescale 1ns/1ns

module adc_seq_checker (
  input wire logic link_srst, // Device reset, active high
  input wire logic conversion_clock, // Conversion clock from the host
  input wire logic cs_n, // Chip select, active low
  input wire logic sclk, // Serial clock
  input wire logic din, // Address bit to the device
  input wire logic dout, // Result bit from the device
  input wire logic dout_oe, // Device drives the result line
  input wire logic conversion_done, // High when no conversion runs
  input wire logic dout_line // Resolved result line
);
  // Helper state: last serial clock level, falls this frame, cycles of conversion
  typedef struct packed {
    logic sclk;
    logic [4:0] falls;
    logic [5:0] low;
  } watch_t;

  watch_t st_q; // Registered helper state
  watch_t st_d; // Next helper state
  logic sclk_fall; // Serial clock fall seen at this edge
  logic tenth_fall; // The tenth fall of a frame

  assign sclk_fall = st_q.sclk & ~sclk;
  assign tenth_fall = sclk_fall && (st_q.falls == 5'h09);

  // Count falls only while selected; a fall that meets the select rise is added in the length check
  always_comb
  begin
    st_d = st_q;
    st_d.sclk = sclk;
    st_d.falls = cs_n ? 5'h00 : st_q.falls + {4'h0, sclk_fall};
    st_d.low = conversion_done ? 6'h00 : st_q.low + 6'h01;
  end

  // Register the helper state
  always_ff @(posedge conversion_clock)
  begin
    if (link_srst)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  default clocking @(posedge conversion_clock); endclocking
  default disable iff (link_srst);

  a_float_when_idle: assert property (cs_n [*4] |-> !dout_oe)
    else $error("result line driven while deselected");
  a_drive_after_select: assert property ($fell(cs_n) |-> ##[2:4] dout_oe)
    else $error("result line not driven after select");
  a_done_after_tenth: assert property (tenth_fall |-> ##[1:5] !conversion_done)
    else $error("conversion did not start after tenth fall");
  a_conv_exact_length: assert property ($rose(conversion_done) |-> st_q.low == 6'h2c)
    else $error("conversion length wrong");
  a_conv_bound: assert property (st_q.low <= 6'h2c)
    else $error("conversion runs too long");
  a_zeros_after_tenth: assert property (!conversion_done && !$past(conversion_done)
    && dout_oe |-> !dout && !dout_line)
    else $error("result line not low after tenth fall");
  a_din_steady: assert property (sclk && st_q.sclk |-> $stable(din))
    else $error("address bit moved while clock high");
  a_select_setup: assert property ($fell(cs_n) |-> !sclk [*3])
    else $error("serial clock too soon after select");
  a_rise_after_tenth: assert property (tenth_fall && !cs_n |-> ##[1:38] (sclk || cs_n))
    else $error("no rise after tenth fall");
  a_transfer_length: assert property ($rose(cs_n)
    |-> (st_q.falls + {4'h0, sclk_fall}) inside {[5'h0a:5'h10]})
    else $error("transfer length out of range");
endmodule // adc_seq_checker

// file: adc_seq_consts.svh
// Timing counts, widths and positions for the serial converter sequencer.
// Assumes the host clock is 100 MHz and the device runs on the conversion clock.
`ifndef ADC_SEQ_CONSTS_SVH
`define ADC_SEQ_CONSTS_SVH

// Result and address widths
`define RESULT_W 10
`define ADDR_W 4
`define RESULT_MSB 9
`define RESULT_RESET 10'h000

// Serial port counts, in serial clock edges
`define ADDR_RISES 5'h04
`define LAST_FALL 5'h0a
`define MAX_FALLS 5'h10
`define ACQ_SCLKS 5'h06
`define ACQ_START_RISE (`ADDR_RISES - 5'h01)

// Conversion counts, in conversion clock cycles
`define CONV_CYCLES 6'h2c
`define ABORT_CYCLES 6'h24

// Host clock and the conversion clock it makes by division
`define CLK_NS 10
`define CONV_HALF_CYC 6'h18
`define CONV_PERIOD_CYC (2 * 24)

// Chip select to first serial edge: two conversion clocks plus 425 ns,
// with two more conversion clocks for the device's pin synchronisers
`define CS_SETUP_NS 425
`define CS_SETUP_CYC 12'((4 * `CONV_PERIOD_CYC) + ((`CS_SETUP_NS + `CLK_NS - 1) / `CLK_NS))

// Serial clock half period: four conversion clocks so the device can oversample
`define SCLK_HALF_CYC 12'(4 * `CONV_PERIOD_CYC)

// Gap after the last fall that lets a conversion finish, with margin
`define ALLOW_GAP_CYC 12'((44 + 8) * `CONV_PERIOD_CYC)

`endif

// file: adc_seq_pkg.sv
// Types shared by both ends of the serial converter link.
// Assumes adc_seq_consts.svh supplies the widths.
`include "adc_seq_consts.svh"

package adc_seq_pkg;

  typedef logic [`RESULT_W-1:0] result_t; // Converted code
  typedef logic [`ADDR_W-1:0] addr_t; // Channel address

  // Device sequencer states, one-hot
  typedef enum logic [2:0] {
    DEV_IDLE = 3'b001,
    DEV_SHIFT = 3'b010,
    DEV_CONV = 3'b100
  } dev_state_t;

  // Host sequencer states, one-hot
  typedef enum logic [4:0] {
    H_IDLE = 5'b00001,
    H_SETUP = 5'b00010,
    H_LOW = 5'b00100,
    H_HIGH = 5'b01000,
    H_GAP = 5'b10000
  } host_state_t;

endpackage

// file: adc_sync2.sv
// Two flip-flop synchroniser for levels entering a clock domain.
// Assumes each bit is an independent level; no reset, so X clears in two edges.
`timescale 1ns/1ns

module adc_sync2 #(
  parameter int W = 1
) (
  input wire logic clk, // Destination clock
  input wire logic [W-1:0] d, // Asynchronous levels
  output logic [W-1:0] q // Synchronised levels
);
  // Both stages in one state word
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_state_t;

  sync_state_t st_q; // Current stages
  sync_state_t st_d; // Next stages

  // First stage feeds only the second
  always_comb
  begin
    st_d.s1 = d;
    st_d.s2 = st_q.s1;
  end

  // Register both stages
  always_ff @(posedge clk)
  begin
    st_q <= st_d;
  end

  assign q = st_q.s2;
endmodule // adc_sync2

// file: tb.sv
// Self-checking bench: host and device joined over the serial link.
// Assumes the host divides clk to make the conversion clock for the device.
`timescale 1ns/1ns

module tb;
  import adc_seq_pkg::*;
  logic clk; // System clock
  logic srst; // Host reset
  logic link_srst; // Device reset
  logic start; // Transfer request
  addr_t chan; // Next channel
  logic [4:0] xfer_len; // Serial clocks per transfer
  result_t sample_code; // Level presented to the device
  logic busy; // Host busy
  result_t result; // Result read back
  logic result_valid; // Result strobe
  addr_t chan_sel; // Channel held by the device
  result_t result_code; // Device output register
  int fail_count; // Mismatches
  int n_tests; // Comparisons
  int cyc; // Cycles run, for the hang limit
  result_t prev; // Result the device should hand back next
  logic conv_prev = 1'b0; // Conversion clock at the previous falling edge
  logic sel_prev = 1'b1; // Select at the previous falling edge
  int conv_rise_at = 0; // Cycle of the last conversion clock rise
  int sel_fall_at = 0; // Cycle of the last select fall
  int span; // Measured interval in ns
  // Reversible channel patterns expose bit order; length 5 must clamp to 10
  addr_t chans[4] = '{4'h5, 4'ha, 4'h3, 4'hf};
  logic [4:0] lens[4] = '{5'h0a, 5'h10, 5'h0d, 5'h05};
  result_t codes[4] = '{10'h2a5, 10'h3c1, 10'h155, 10'h0ff};

  adc_link_if adc_link_if_i ();

  adc_host adc_host_i (
    .clk(clk), .srst(srst), .link(adc_link_if_i), .start(start), .chan(chan),
    .xfer_len(xfer_len), .busy(busy), .result(result), .result_valid(result_valid)
  );

  adc_device adc_device_i (
    .link_srst(link_srst), .link(adc_link_if_i), .sample_code(sample_code),
    .chan_sel(chan_sel), .result_code(result_code)
  );

  adc_seq_checker adc_seq_checker_i (
    .link_srst(link_srst), .conversion_clock(adc_link_if_i.conversion_clock),
    .cs_n(adc_link_if_i.cs_n), .sclk(adc_link_if_i.sclk), .din(adc_link_if_i.din),
    .dout(adc_link_if_i.dout), .dout_oe(adc_link_if_i.dout_oe),
    .conversion_done(adc_link_if_i.conversion_done), .dout_line(adc_link_if_i.dout_line)
  );

  // 100 MHz system clock
  always #5 clk = ~clk;

  // Compare and count
  task check(input string what, input logic [9:0] seen, input logic [9:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Print counts and verdict, then stop
  task summarize;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // One transfer: start, read back the previous result, then let the gap run out
  task run(input int k);
    int n;
    chan = chans[k];
    xfer_len = lens[k];
    sample_code = codes[k];
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    n = 0;
    while (result_valid !== 1'b1 && n < 12000)
    begin
      @(negedge clk);
      n++;
    end
    check("valid", {9'h000, result_valid}, 10'h001);
    check("result", result, prev);
    // A start during the gap must be dropped, not queued
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    n = 0;
    while (busy !== 1'b0 && n < 4000)
    begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    check("busy", {9'h000, busy}, 10'h000);
    check("channel", {6'h00, chan_sel}, {6'h00, chans[k]});
    check("conversion", result_code, codes[k]);
    check("done", {9'h000, adc_link_if_i.conversion_done}, 10'h001);
    check("float", {9'h000, adc_link_if_i.dout_line}, 10'h001);
    prev = codes[k];
  endtask

  // Main sequence: host out of reset first so the conversion clock runs
  initial
  begin
    clk = 1'b0;
    srst = 1'b1;
    link_srst = 1'b1;
    start = 1'b0;
    chan = 4'h0;
    xfer_len = 5'h0a;
    sample_code = 10'h000;
    fail_count = 0;
    n_tests = 0;
    prev = 10'h000;
    repeat (12) @(negedge clk);
    srst = 1'b0;
    repeat (300) @(negedge clk);
    link_srst = 1'b0;
    repeat (200) @(negedge clk);
    check("idle result", result_code, 10'h000);
    check("idle channel", {6'h00, chan_sel}, 10'h000);
    check("idle line", {9'h000, adc_link_if_i.dout_line}, 10'h001);
    for (int k = 0; k < 4; k++)
    begin
      run(k);
    end
    summarize();
  end

  // Host-made link timing seen at the pins: clock band and sample-cycle spacing
  always @(negedge clk)
  begin
    if (adc_link_if_i.conversion_clock && !conv_prev)
    begin
      span = (cyc - conv_rise_at) * 10;
      if (conv_rise_at > 0)
      begin
        check("clock band", {9'h000, span * 21 >= 10000 && span <= 2000}, 10'h001);
      end
      conv_rise_at = cyc;
    end
    if (!adc_link_if_i.cs_n && sel_prev)
    begin
      span = (cyc - sel_fall_at) * 10;
      if (sel_fall_at > 0)
      begin
        check("cycle spacing", {9'h000, span >= 26000}, 10'h001);
      end
      sel_fall_at = cyc;
    end
    conv_prev = adc_link_if_i.conversion_clock;
    sel_prev = adc_link_if_i.cs_n;
  end

  // Hang limit: about twice the expected run
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      fail_count++;
      summarize();
    end
  end

  initial cyc = 0;
endmodule // tb
